// >>> pkg/coproc_move_multiply_decode_map.svh
// Purpose: Offsets, field positions, reset values and opcode patterns of the decoder.
// Assumes: 32-bit APB, one aligned word per register.
// Notes:   Definitions only.
`ifndef COPROC_MOVE_MULTIPLY_DECODE_MAP_SVH
`define COPROC_MOVE_MULTIPLY_DECODE_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFF_INSTR        12'h000
`define OFF_CTRL         12'h004
`define OFF_STATUS       12'h008
`define OFF_IRQ_STATUS   12'h00C
`define OFF_IRQ_MASK     12'h010
`define OFF_CONTROL_REG  12'h014
`define OFF_PRIMASK_REG  12'h018
`define OFF_GPR_BASE     12'h040
`define OFF_GPR_LAST     12'h078

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_COND_PASS   0
`define CTRL_IN_BLOCK    1
`define CTRL_PRIV        2
`define CTRL_NARROW      3
`define CTRL_RESET       4'h5
`define IRQ_DONE         0
`define IRQ_FAULT        1
`define IRQ_UNPRED       2
`define IRQ_RESET        3'h0
`define FLAGS_RESET      4'h0

// ****************************************************************
// Opcode patterns and special register numbers
// ****************************************************************
`define TOP3_32BIT       3'h7
`define CP_SINGLE_MID    4'hE
`define CP_DUAL_MID      8'hC5
`define SREG_READ_TOP    12'hF3E
`define SREG_WRITE_TOP   11'h79C
`define MUL_WIDE_TOP     12'hFB0
`define MUL_NARROW_TOP   10'h10D
`define REG_SP           4'hD
`define REG_PC           4'hF
`define SPECIAL_REG_SELECT_PRIMASK     8'h10
`define SPECIAL_REG_SELECT_CONTROL     8'h14
`define SPECIAL_REG_SELECT_APPLICATION_STATUS_REG_LAST   8'h03

`endif

// >>> pkg/cp_decode_pkg.sv
// Purpose: Types shared by the decoder files.
// Assumes: Nothing beyond the map header.
// Notes:   States and instruction classes carry no fixed codes.
package cp_decode_pkg;
	// Sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CP_WAIT} state_type;
	// Instruction classes of this group
	typedef enum logic [2:0] {
		K_NONE, K_CP_SINGLE, K_CP_DUAL, K_SREG_READ, K_SREG_WRITE, K_MUL_NARROW, K_MUL_WIDE
	} instr_kind_type;
endpackage

// >>> src/instr_field_decode.sv
// Purpose: Classifies one instruction word and extracts its fields.
// Assumes: Wide forms hold first halfword in 31:16; narrow form sits in 15:0.
// Notes:   Purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "coproc_move_multiply_decode_map.svh"
module instr_field_decode (
	input  wire logic [31:0]                  instr,
	input  wire logic                         narrow,
	input  wire logic                         in_cond_block,
	output var  cp_decode_pkg::instr_kind_type kind,
	output logic                              is_alt,
	output logic [3:0]                        cp_num,
	output logic [3:0]                        coproc_first_opcode,
	output logic [3:0]                        coproc_first_reg_field,
	output logic [3:0]                        coproc_extra_reg_field,
	output logic [2:0]                        coproc_second_opcode,
	output logic [3:0]                        rt,
	output logic [3:0]                        rt2,
	output logic [3:0]                        rd,
	output logic [3:0]                        rn,
	output logic [3:0]                        rm,
	output logic [7:0]                        special_reg_select,
	output logic [1:0]                        mask,
	output logic                              set_flags,
	output logic                              unpred
);
	import cp_decode_pkg::*;

	// ****************************************************************
	// Field extraction and classification
	// ****************************************************************
	always_comb begin
		kind      = K_NONE;
		unpred    = 1'b0;
		set_flags = 1'b0;
		is_alt    = instr[28];
		cp_num    = instr[11:8];
		coproc_first_opcode      = {1'b0, instr[23:21]};
		coproc_first_reg_field       = instr[19:16];
		coproc_extra_reg_field       = instr[3:0];
		coproc_second_opcode      = instr[7:5];
		rt        = instr[15:12];
		rt2       = instr[19:16];
		rd        = instr[11:8];
		rn        = instr[19:16];
		rm        = instr[3:0];
		special_reg_select      = instr[7:0];
		mask      = instr[11:10];
		if (narrow) begin
			// Narrow multiply: one field is source and destination
			if (instr[15:6] == `MUL_NARROW_TOP) begin
				kind      = K_MUL_NARROW;
				rn        = {1'b0, instr[5:3]};
				rm        = {1'b0, instr[2:0]};
				rd        = {1'b0, instr[2:0]};
				set_flags = !in_cond_block;
			end
		end else if (instr[31:29] == `TOP3_32BIT && instr[27:24] == `CP_SINGLE_MID && instr[20] && instr[4]) begin
			kind   = K_CP_SINGLE;
			unpred = (rt == `REG_SP);
		end else if (instr[31:29] == `TOP3_32BIT && instr[27:20] == `CP_DUAL_MID) begin
			kind   = K_CP_DUAL;
			coproc_first_opcode   = instr[7:4];
			unpred = (rt == `REG_PC) || (rt2 == `REG_PC) || (rt == rt2)
				|| (rt == `REG_SP) || (rt2 == `REG_SP);
		end else if (instr[31:20] == `SREG_READ_TOP && instr[15:14] == 2'h2 && !instr[12]) begin
			kind = K_SREG_READ;
		end else if (instr[31:21] == `SREG_WRITE_TOP && instr[15:14] == 2'h2 && !instr[12]) begin
			kind = K_SREG_WRITE;
		end else if (instr[31:20] == `MUL_WIDE_TOP && instr[15:12] == 4'hF && instr[7:4] == 4'h0) begin
			kind   = K_MUL_WIDE;
			unpred = rd == `REG_SP || rd == `REG_PC || rn == `REG_SP || rn == `REG_PC
				|| rm == `REG_SP || rm == `REG_PC;
		end else begin
			kind = K_NONE;
		end
	end
endmodule // instr_field_decode
`default_nettype wire

// >>> src/mul_low_word.sv
// Purpose: Low word of a 32 by 32 product with its sign and zero bits.
// Assumes: Operands come from the register file.
// Notes:   Combinational; the low word is the same for signed and unsigned.
`timescale 1ns/100ps
`default_nettype none
module mul_low_word (
	input  wire logic [31:0] op_a,
	input  wire logic [31:0] op_b,
	output logic      [31:0] low,
	output logic             neg,
	output logic             zero
);
	// Full unsigned product; only its low half is kept
	logic [63:0] full;

	// ****************************************************************
	// Product and result bits
	// ****************************************************************
	always_comb begin
		full = op_a * op_b;
		low  = full[31:0];
		neg  = full[31];
		zero = (full[31:0] == 32'h0000_0000);
	end
endmodule // mul_low_word
`default_nettype wire

// >>> src/coproc_move_multiply_decode.sv
// Purpose: Executes coprocessor reads, special register moves and multiply.
// Assumes: Coprocessors run on pclk and answer every request.
// Notes:   Software loads operands, writes an instruction and reads results.
//
// What this block does
// - Single read to stack pointer is unpredictable
// - All-ones destination loads flags from bits 31:28
// - Other destinations take the whole word
// - Rejected transfer faults, nothing changes
// - Pass three-bit opcode and register fields
// - Four-bit number selects exactly one coprocessor
// - One first-halfword bit marks alternate form
// - Dual read writes two words to two registers
// - Dual read: pc or equal destinations unpredictable
// - Dual read: stack pointer destination unpredictable
// - Dual read passes four-bit opcode, one register
// - Special read privileged except status, control
// - Special write privileged except status register
// - Multiply keeps low word, sign independent
// - Narrow multiply shares field, flags outside block
// - Wide multiply never sets flags; sp, pc unpredictable
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "coproc_move_multiply_decode_map.svh"
module coproc_move_multiply_decode (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             cp_req,
	output logic      [15:0] cp_sel,
	output logic      [3:0]  cp_num,
	output logic             cp_alt,
	output logic             cp_dual,
	output logic      [3:0]  cp_first_opcode,
	output logic      [3:0]  cp_first_reg,
	output logic      [3:0]  cp_extra_reg,
	output logic      [2:0]  cp_second_opcode,
	input  wire logic        cp_resp,
	input  wire logic        cp_accept,
	input  wire logic [31:0] cp_word0,
	input  wire logic [31:0] cp_word1
);
	import cp_decode_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		state_type        st;        // Sequencer
		logic [14:0][31:0] gpr;      // General registers 0 to 14
		logic [3:0]       flags;     // N Z C V
		logic [1:0]       control;   // Control special register
		logic             primask;   // Priority mask special register
		logic [31:0]      instr;     // Instruction being executed
		logic [3:0]       ctrl;      // Condition, block, privilege, narrow
		logic [2:0]       irq_st;    // Sticky events
		logic [2:0]       irq_mask;  // Event enables
		logic [31:0]      prdata;    // Read data
		logic             pready;    // Access answer
		logic             pslverr;   // Access error
		logic             irq;       // Interrupt level
		logic             cp_req;    // Coprocessor request
		logic [15:0]      cp_sel;    // One-hot coprocessor select
		logic [3:0]       cp_num;    // Coprocessor number
		logic             cp_alt;    // Alternate form
		logic             cp_dual;   // Two-word transfer
		logic [3:0]       cp_coproc_first_opcode;   // First opcode
		logic [3:0]       cp_crn;    // First register field
		logic [3:0]       cp_crm;    // Extra register field
		logic [2:0]       cp_coproc_second_opcode;   // Second opcode
		logic [3:0]       cp_rt;     // First destination
		logic [3:0]       cp_rt2;    // Second destination
	} regs_type;

	regs_type       state_q;   // Registered state
	regs_type       state_d;   // Next state

	// Decoder outputs
	instr_kind_type kind;
	logic           is_alt;
	logic [3:0]     dec_cp;
	logic [3:0]     dec_coproc_first_opcode;
	logic [3:0]     dec_crn;
	logic [3:0]     dec_crm;
	logic [2:0]     dec_coproc_second_opcode;
	logic [3:0]     dec_rt;
	logic [3:0]     dec_rt2;
	logic [3:0]     dec_rd;
	logic [3:0]     dec_rn;
	logic [3:0]     dec_rm;
	logic [7:0]     dec_special_reg_select;
	logic [1:0]     dec_mask;
	logic           dec_setf;
	logic           dec_unpred;

	// Multiplier outputs and operands
	logic [31:0]    op_a;
	logic [31:0]    op_b;
	logic [31:0]    prod;
	logic           prod_neg;
	logic           prod_zero;

	// Access decode helpers
	logic           setup;
	logic           wr_acc;
	logic [3:0]     gpr_idx;
	logic           gpr_hit;
	logic [31:0]    sreg_val;
	logic [2:0]     ev;

	// ****************************************************************
	// Submodules
	// ****************************************************************
	instr_field_decode u_dec (
		.instr         (state_q.instr),
		.narrow        (state_q.ctrl[`CTRL_NARROW]),
		.in_cond_block (state_q.ctrl[`CTRL_IN_BLOCK]),
		.kind          (kind),
		.is_alt        (is_alt),
		.cp_num        (dec_cp),
		.coproc_first_opcode          (dec_coproc_first_opcode),
		.coproc_first_reg_field           (dec_crn),
		.coproc_extra_reg_field           (dec_crm),
		.coproc_second_opcode          (dec_coproc_second_opcode),
		.rt            (dec_rt),
		.rt2           (dec_rt2),
		.rd            (dec_rd),
		.rn            (dec_rn),
		.rm            (dec_rm),
		.special_reg_select          (dec_special_reg_select),
		.mask          (dec_mask),
		.set_flags     (dec_setf),
		.unpred        (dec_unpred)
	);

	// Out-of-range indices only occur on unpredictable encodings
	assign op_a = (dec_rn == `REG_PC) ? 32'h0000_0000 : state_q.gpr[dec_rn];
	assign op_b = (dec_rm == `REG_PC) ? 32'h0000_0000 : state_q.gpr[dec_rm];

	mul_low_word u_mul (
		.op_a (op_a),
		.op_b (op_b),
		.low  (prod),
		.neg  (prod_neg),
		.zero (prod_zero)
	);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		state_d  = state_q;
		ev       = 3'h0;
		setup    = psel && !penable;
		wr_acc   = psel && penable && pwrite && state_q.pready;
		gpr_idx  = paddr[5:2];
		gpr_hit  = paddr >= `OFF_GPR_BASE && paddr <= `OFF_GPR_LAST && paddr[1:0] == 2'h0;
		sreg_val = 32'h0000_0000;

		// Answer in the cycle after setup, read data ready with it
		state_d.pready  = setup;
		state_d.pslverr = 1'b0;
		if (setup) begin
			state_d.prdata = 32'h0000_0000;
			case (paddr)
				`OFF_INSTR:       state_d.prdata = state_q.instr;
				`OFF_CTRL:        state_d.prdata = {28'h000_0000, state_q.ctrl};
				`OFF_STATUS:      state_d.prdata = {20'h0_0000, state_q.cp_num, state_q.flags,
					3'h0, state_q.st != ST_IDLE};
				`OFF_IRQ_STATUS:  state_d.prdata = {29'h0000_0000, state_q.irq_st};
				`OFF_IRQ_MASK:    state_d.prdata = {29'h0000_0000, state_q.irq_mask};
				`OFF_CONTROL_REG: state_d.prdata = {30'h0000_0000, state_q.control};
				`OFF_PRIMASK_REG: state_d.prdata = {31'h0000_0000, state_q.primask};
				default: begin
					if (gpr_hit) begin
						state_d.prdata = state_q.gpr[gpr_idx];
					end else begin
						state_d.pslverr = 1'b1;  // Unmapped address
					end
				end
			endcase
			// Instruction write while busy is refused
			if (pwrite && paddr == `OFF_INSTR && state_q.st != ST_IDLE) begin
				state_d.pslverr = 1'b1;
			end
		end

		// Register writes take effect at the access edge
		if (wr_acc && !state_q.pslverr) begin
			case (paddr)
				`OFF_INSTR: begin
					state_d.instr = pwdata;
					state_d.st    = ST_EXEC;
				end
				`OFF_CTRL:        state_d.ctrl     = pwdata[3:0];
				`OFF_IRQ_MASK:    state_d.irq_mask = pwdata[2:0];
				`OFF_CONTROL_REG: state_d.control  = pwdata[1:0];
				`OFF_PRIMASK_REG: state_d.primask  = pwdata[0];
				`OFF_STATUS: state_d.flags = pwdata[7:4];
				default: begin
					if (gpr_hit) begin
						state_d.gpr[gpr_idx] = pwdata;
					end
				end
			endcase
		end

		// Sequencer
		case (state_q.st)
			ST_IDLE: begin
				state_d.cp_req = 1'b0;
			end
			ST_EXEC: begin
				state_d.st = ST_IDLE;
				ev[`IRQ_DONE] = 1'b1;
				if (!state_q.ctrl[`CTRL_COND_PASS]) begin
					ev[`IRQ_DONE] = 1'b1;
				end else if (kind == K_NONE) begin
					ev[`IRQ_FAULT] = 1'b1;
				end else if (dec_unpred) begin
					ev[`IRQ_UNPRED] = 1'b1;
				end else begin
					case (kind)
						K_CP_SINGLE, K_CP_DUAL: begin
							ev[`IRQ_DONE]    = 1'b0;
							state_d.st       = ST_CP_WAIT;
							state_d.cp_req   = 1'b1;
							state_d.cp_num   = dec_cp;
							state_d.cp_sel   = 16'h0001 << dec_cp;
							state_d.cp_alt   = is_alt;
							state_d.cp_dual  = (kind == K_CP_DUAL);
							state_d.cp_coproc_first_opcode  = dec_coproc_first_opcode;
							state_d.cp_crn   = (kind == K_CP_DUAL) ? 4'h0 : dec_crn;
							state_d.cp_crm   = dec_crm;
							state_d.cp_coproc_second_opcode  = (kind == K_CP_DUAL) ? 3'h0 : dec_coproc_second_opcode;
							state_d.cp_rt    = dec_rt;
							state_d.cp_rt2   = dec_rt2;
						end
						K_SREG_READ: begin
							if (dec_special_reg_select <= `SPECIAL_REG_SELECT_APPLICATION_STATUS_REG_LAST) begin
								sreg_val = {state_q.flags, 28'h000_0000};
							end else if (dec_special_reg_select == `SPECIAL_REG_SELECT_CONTROL) begin
								sreg_val = {30'h0000_0000, state_q.control};
							end else if (dec_special_reg_select == `SPECIAL_REG_SELECT_PRIMASK && state_q.ctrl[`CTRL_PRIV]) begin
								sreg_val = {31'h0000_0000, state_q.primask};
							end else begin
								sreg_val = 32'h0000_0000;
							end
							if (dec_rd < `REG_PC) begin
								state_d.gpr[dec_rd] = sreg_val;
							end
						end
						K_SREG_WRITE: begin
							if (dec_special_reg_select <= `SPECIAL_REG_SELECT_APPLICATION_STATUS_REG_LAST && dec_mask[1] && dec_rn < `REG_PC) begin
								state_d.flags = state_q.gpr[dec_rn][31:28];
							end else if (state_q.ctrl[`CTRL_PRIV] && dec_rn < `REG_PC) begin
								if (dec_special_reg_select == `SPECIAL_REG_SELECT_CONTROL) begin
									state_d.control = state_q.gpr[dec_rn][1:0];
								end else if (dec_special_reg_select == `SPECIAL_REG_SELECT_PRIMASK) begin
									state_d.primask = state_q.gpr[dec_rn][0];
								end
							end
						end
						K_MUL_NARROW, K_MUL_WIDE: begin
							state_d.gpr[dec_rd] = prod;
							if (kind == K_MUL_NARROW && dec_setf) begin
								state_d.flags[3] = prod_neg;
								state_d.flags[2] = prod_zero;
							end
						end
						default: begin
							ev[`IRQ_FAULT] = 1'b1;
						end
					endcase
				end
			end
			ST_CP_WAIT: begin
				if (cp_resp) begin
					state_d.cp_req = 1'b0;
					state_d.st     = ST_IDLE;
					ev[`IRQ_DONE]  = 1'b1;
					if (!cp_accept) begin
						ev[`IRQ_FAULT] = 1'b1;
					end else if (state_q.cp_dual) begin
						state_d.gpr[state_q.cp_rt]  = cp_word0;
						state_d.gpr[state_q.cp_rt2] = cp_word1;
					end else if (state_q.cp_rt == `REG_PC) begin
						state_d.flags = cp_word0[31:28];
					end else begin
						state_d.gpr[state_q.cp_rt] = cp_word0;
					end
				end
			end
			default: begin
				state_d.st = ST_IDLE;
			end
		endcase

		// Sticky events: set wins over a write-one clear
		if (wr_acc && paddr == `OFF_IRQ_STATUS) begin
			state_d.irq_st = state_q.irq_st & ~pwdata[2:0];
		end
		state_d.irq_st = state_d.irq_st | ev;
		state_d.irq    = |(state_d.irq_st & state_d.irq_mask);
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q          <= '0;
			state_q.st       <= ST_IDLE;
			state_q.ctrl     <= `CTRL_RESET;
			state_q.flags    <= `FLAGS_RESET;
			state_q.irq_st   <= `IRQ_RESET;
			state_q.irq_mask <= `IRQ_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs straight from the state register
	assign prdata           = state_q.prdata;
	assign pready           = state_q.pready;
	assign pslverr          = state_q.pslverr;
	assign irq              = state_q.irq;
	assign cp_req           = state_q.cp_req;
	assign cp_sel           = state_q.cp_sel;
	assign cp_num           = state_q.cp_num;
	assign cp_alt           = state_q.cp_alt;
	assign cp_dual          = state_q.cp_dual;
	assign cp_first_opcode  = state_q.cp_coproc_first_opcode;
	assign cp_first_reg     = state_q.cp_crn;
	assign cp_extra_reg     = state_q.cp_crm;
	assign cp_second_opcode = state_q.cp_coproc_second_opcode;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_cp_sel_onehot: assert property (cp_req |-> cp_sel == (16'h0001 << cp_num))
		else $error("select not one-hot on number");
	a_cp_alt_bit: assert property ($rose(cp_req) |-> cp_alt == state_q.instr[28])
		else $error("alternate bit mismatch");
	a_reject_no_change: assert property (cp_req && cp_resp && !cp_accept |=>
		state_q.gpr == $past(state_q.gpr) && state_q.flags == $past(state_q.flags)
		&& state_q.irq_st[`IRQ_FAULT] && !cp_req)
		else $error("reject changed state or no fault");
	a_single_flags: assert property (cp_req && cp_resp && cp_accept && !cp_dual
		&& state_q.cp_rt == `REG_PC |=> state_q.flags == $past(cp_word0[31:28]))
		else $error("flags not loaded from word");
	a_single_gpr: assert property (cp_req && cp_resp && cp_accept && !cp_dual
		&& state_q.cp_rt != `REG_PC |=> state_q.gpr[$past(state_q.cp_rt)] == $past(cp_word0))
		else $error("register not written with word");
	a_dual_pair: assert property (cp_req && cp_resp && cp_accept && cp_dual |=>
		state_q.gpr[$past(state_q.cp_rt)] == $past(cp_word0)
		&& state_q.gpr[$past(state_q.cp_rt2)] == $past(cp_word1))
		else $error("dual words not written");
	a_unpred_blocked: assert property (state_q.st == ST_EXEC && state_q.ctrl[`CTRL_COND_PASS]
		&& kind != K_NONE && dec_unpred |=> !cp_req && state_q.irq_st[`IRQ_UNPRED])
		else $error("unpredictable encoding executed");
	a_wide_mul_noflags: assert property (state_q.st == ST_EXEC && kind == K_MUL_WIDE
		|=> state_q.flags == $past(state_q.flags))
		else $error("wide multiply changed flags");
	a_mul_low_word: assert property (state_q.st == ST_EXEC && state_q.ctrl[`CTRL_COND_PASS]
		&& (kind == K_MUL_WIDE || kind == K_MUL_NARROW) && !dec_unpred
		|=> state_q.gpr[$past(dec_rd)] == $past(prod))
		else $error("product low word not written");
	a_cond_fail_quiet: assert property (state_q.st == ST_EXEC && !state_q.ctrl[`CTRL_COND_PASS]
		|=> state_q.flags == $past(state_q.flags) && !cp_req ##1 !cp_req)
		else $error("failed condition had an effect");
endmodule // coproc_move_multiply_decode
`default_nettype wire

// >>> tb/coproc_bank.sv
// Purpose: Bank of coprocessors answering transfer requests.
// Assumes: Same clock as the decoder; one request at a time.
// Notes:   Delay, presence and words are set by the bench.
`timescale 1ns/100ps
`default_nettype none
module coproc_bank (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        cp_req,
	input  wire logic [15:0] cp_sel,
	input  wire logic [15:0] present,
	input  wire logic [2:0]  delay,
	input  wire logic [31:0] word0,
	input  wire logic [31:0] word1,
	output logic             cp_resp,
	output logic             cp_accept,
	output logic      [31:0] cp_word0,
	output logic      [31:0] cp_word1
);
	logic       pend_q; // Answer pending
	logic [2:0] cnt_q;  // Cycles left
	// One answer per request, after the chosen delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{pend_q, cnt_q, cp_resp, cp_accept, cp_word0, cp_word1} <= '0;
		end else begin
			cp_resp  <= 1'b0;
			cp_word0 <= ~cp_word0; // Words carry nothing outside an answer
			cp_word1 <= ~cp_word1;
			if (cp_req && !cp_resp && !pend_q) begin
				pend_q <= 1'b1;
				cnt_q  <= delay;
			end else if (pend_q && cnt_q != 3'h0) begin
				cnt_q <= cnt_q - 3'h1;
			end else if (pend_q) begin
				pend_q    <= 1'b0;
				cp_resp   <= 1'b1;
				cp_accept <= |(cp_sel & present);
				cp_word0  <= word0;
				cp_word1  <= word1;
			end
		end
	end
endmodule // coproc_bank
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Random and corner checks of the decoder through APB.
// Assumes: Zero-wait APB, registers as in the map header.
// Notes:   Expected values come from bench encoders.
`timescale 1ns/100ps
`default_nettype none
`include "coproc_move_multiply_decode_map.svh"
module tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, w0, w1, a, b;
	logic pready, pslverr, irq, cp_req, cp_alt, cp_dual, cp_resp, cp_accept;
	logic [15:0] cp_sel, present = '1;
	logic [3:0]  cp_num, cp_first_opcode, cp_first_reg, cp_extra_reg, rt, cp;
	logic [2:0]  cp_second_opcode, delay = '0, o1, o2;
	logic [31:0] cp_word0, cp_word1;
	logic [36:0] cap; // Request fields seen while cp_req high
	logic [7:0]  bad [3] = '{8'h55, 8'hF4, 8'h4D};
	int failures = 0, compares = 0, nreq = 0, i, j, k;
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) if (cp_req) cap <= {cp_sel, cp_num, cp_first_opcode, cp_first_reg,
		cp_extra_reg, cp_alt, cp_dual, cp_second_opcode};
	always @(posedge cp_req) nreq++;
	coproc_move_multiply_decode dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq, .cp_req, .cp_sel, .cp_num, .cp_alt, .cp_dual,
		.cp_first_opcode, .cp_first_reg, .cp_extra_reg, .cp_second_opcode, .cp_resp,
		.cp_accept, .cp_word0, .cp_word1);
	coproc_bank bank (.pclk, .presetn, .cp_req, .cp_sel, .present, .delay, .word0(w0),
		.word1(w1), .cp_resp, .cp_accept, .cp_word0, .cp_word1);
	// Encoders for single and dual coprocessor reads
	function automatic logic [31:0] enc1(logic c, logic [2:0] p, logic [3:0] n, t, q, logic [2:0] s,
		logic [3:0] m);
		return {3'b111, c, 4'hE, p, 1'b1, n, t, q, s, 1'b1, m};
	endfunction
	function automatic logic [31:0] enc2(logic c, logic [3:0] t2, t, q, p, m);
		return {3'b111, c, 8'hC5, t2, t, q, p, m};
	endfunction
	task automatic chk(input string n, input logic [36:0] e, g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// One APB transfer, held until pready
	task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 9; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 9) begin
			failures++;
			report_and_stop;
		end
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rg(input logic [3:0] n);
		bus(0, `OFF_GPR_BASE + {6'h0, n, 2'b00}, 32'h0);
	endtask
	task automatic wg(input logic [3:0] n, input logic [31:0] v);
		bus(1, `OFF_GPR_BASE + {6'h0, n, 2'b00}, v);
	endtask
	// Clear events, issue, wait idle, leave event bits in rd
	task automatic run(input logic [31:0] ins);
		bus(1, `OFF_IRQ_STATUS, 32'h0000_0007);
		bus(1, `OFF_INSTR, ins);
		for (j = 0; j < 40; j++) begin
			bus(0, `OFF_STATUS, 32'h0);
			if (rd[0] === 1'b0) break;
		end
		if (j == 40) begin
			failures++;
			report_and_stop;
		end
		bus(0, `OFF_IRQ_STATUS, 32'h0);
	endtask
	initial begin
		void'($urandom(32'hbafa536e));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		bus(0, `OFF_CTRL, 32'h0);
		chk("ctrl", 37'h5, rd);
		bus(1, `OFF_IRQ_MASK, 32'h0000_0001);
		for (i = 0; i < 8; i++) begin
			{rt, cp, o1, o2, delay} = {4'($urandom_range(12)), 13'($urandom)};
			{w0, a} = {$urandom, $urandom};
			run(enc1(i[0], o1, a[3:0], rt, cp, o2, a[7:4]));
			chk("events", 37'h9, {irq, rd[2:0]});
			chk("req", {16'h1 << cp, cp, 1'b0, o1, a[3:0], a[7:4], i[0], 1'b0, o2}, cap);
			rg(rt);
			chk("gpr", w0, rd);
		end
		run(enc1(0, 3'h1, 4'h2, 4'hF, cp, 3'h3, 4'h4));
		bus(0, `OFF_STATUS, 32'h0);
		chk("flags", w0[31:28], rd[7:4]);
		i = nreq;
		run(enc1(0, 3'h0, 4'h0, 4'hD, cp, 3'h0, 4'h0));
		chk("unpred", {i, 3'h5}, {nreq, rd[2:0]});
		wg(6, 32'h1234_5678);
		present = ~(16'h1 << cp);
		run(enc1(1, 3'h1, 4'h2, 4'h6, cp, 3'h3, 4'h4));
		chk("fault", 37'h3, rd[2:0]);
		rg(6);
		chk("kept", 32'h1234_5678, rd);
		present = '1;
		{w0, w1} = {$urandom, $urandom};
		run(enc2(1, 4'h5, 4'h4, cp, o1, 4'h9));
		chk("dreq", {16'h1 << cp, cp, 1'b0, o1, 8'h09, 2'b11, 3'h0}, cap);
		rg(4);
		chk("d0", w0, rd);
		rg(5);
		chk("d1", w1, rd);
		for (i = 0; i < 3; i++) begin
			run(enc2(0, bad[i][7:4], bad[i][3:0], cp, 4'h0, 4'h0));
			chk("dunp", 37'h5, rd[2:0]);
		end
		{a, b} = {$urandom, $urandom};
		w0 = a * b;
		wg(1, a);
		wg(2, b);
		bus(1, `OFF_STATUS, 32'h0000_0060);
		run({12'hFB0, 4'h1, 4'hF, 4'h3, 4'h0, 4'h2});
		rg(3);
		chk("mul", w0, rd);
		bus(0, `OFF_STATUS, 32'h0);
		chk("mflags", 37'h6, rd[7:4]);
		run({12'hFB0, 4'h1, 4'hF, 4'hD, 4'h0, 4'h2});
		chk("munp", 37'h5, rd[2:0]);
		for (i = 0; i < 2; i++) begin
			wg(2, b);
			bus(1, `OFF_CTRL, {28'h0, 2'b11, i[0], 1'b1});
			bus(1, `OFF_STATUS, 32'h0000_0060);
			run({16'h0, 10'h10D, 3'h1, 3'h2});
			rg(2);
			chk("nmul", w0, rd);
			bus(0, `OFF_STATUS, 32'h0);
			chk("nflags", i[0] ? 4'h6 : {w0[31], w0 == 0, 2'b10}, rd[7:4]);
		end
		wg(3, 32'h0);
		bus(1, `OFF_CTRL, 32'h0000_0004);
		run({12'hFB0, 4'h1, 4'hF, 4'h3, 4'h0, 4'h2});
		chk("nocond", 37'h1, rd[2:0]);
		rg(3);
		chk("nocond", 37'h0, rd);
		bus(1, `OFF_CTRL, 32'h0000_0001);
		bus(1, `OFF_CONTROL_REG, 32'h0000_0002);
		bus(1, `OFF_PRIMASK_REG, 32'h0000_0001);
		for (i = 0; i < 2; i++) begin
			run({12'hF3E, 4'hF, 4'h8, 4'h7, i[0] ? 8'h10 : 8'h14});
			rg(7);
			chk("sread", i[0] ? 37'h0 : 37'h2, rd);
		end
		wg(8, 32'hA000_0000);
		run({12'hF38, 4'h8, 4'h8, 4'h8, 8'h00});
		run({12'hF38, 4'h8, 4'h8, 4'h8, 8'h14});
		bus(0, `OFF_STATUS, 32'h0);
		chk("swrite", 37'hA, rd[7:4]);
		bus(0, `OFF_CONTROL_REG, 32'h0);
		chk("sctrl", 37'h2, rd[1:0]);
		bus(1, `OFF_IRQ_STATUS, 32'h0000_0007);
		repeat (2) @(posedge pclk);
		chk("irq", 37'h0, irq);
		bus(0, 12'h0FC, 32'h0);
		chk("err", 37'h1, er);
		report_and_stop;
	end
endmodule // tb
`default_nettype wire
